// *** core/sfes_pkg.sv ***
// Purpose: shared constants of the serial flash erase sequencer
// Assumes: 10 MHz system clock on both ends
// Notes:   times in their own unit, cycle counts derived from them
package sfes_pkg;
  localparam int CLK_HZ          = 10_000_000;
  localparam int CLK_PER_US      = CLK_HZ / 1_000_000;
  // link clock half period made by the host divider
  localparam int SCK_HALF_NS     = 400;
  localparam int SCK_HALF_CYC    = SCK_HALF_NS * CLK_PER_US / 1000;
  // longest erase times, plain defaults
  localparam int BLOCK_ERASE_TIME_US  = 1000;
  localparam int SECTOR_ERASE_TIME_US = 4000;
  localparam int CHIP_ERASE_TIME_US   = 20000;
  localparam int BLOCK_ERASE_CYC  = BLOCK_ERASE_TIME_US * CLK_PER_US;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_PER_US;
  localparam int CHIP_ERASE_CYC   = CHIP_ERASE_TIME_US * CLK_PER_US;
  // command bytes
  localparam logic [7:0] OP_BLOCK_ERASE  = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7c;
  localparam logic [7:0] OP_CHIP_1       = 8'hc7;
  localparam logic [7:0] OP_CHIP_2       = 8'h94;
  localparam logic [7:0] OP_CHIP_3       = 8'h80;
  localparam logic [7:0] OP_CHIP_4       = 8'h9a;
  localparam logic [7:0] ERASED_FILL     = 8'hff;
  // array geometry in pages
  localparam logic [7:0] PAGES_PER_BLOCK  = 8'h08;
  localparam logic [7:0] PAGES_PER_SECTOR = 8'h80;
  localparam logic [7:0] SECTOR0B_PAGES   = 8'h78;
  localparam int         NUM_SECTORS      = 64;
  // host register word addresses
  localparam logic [2:0] REG_CMD      = 3'h0;
  localparam logic [2:0] REG_ADDR     = 3'h1;
  localparam logic [2:0] REG_STATUS   = 3'h2;
  localparam logic [2:0] REG_IRQ_STAT = 3'h3;
  localparam logic [2:0] REG_IRQ_CLR  = 3'h4;
  localparam logic [2:0] REG_IRQ_EN   = 3'h5;
  // command kinds written to the command register
  localparam logic [1:0] KIND_BLOCK  = 2'h0;
  localparam logic [1:0] KIND_SECTOR = 2'h1;
  localparam logic [1:0] KIND_CHIP   = 2'h2;
  // field positions
  localparam int ST_SENDING  = 0;
  localparam int ST_DEV_BUSY = 1;
  localparam int ST_DEV_ERR  = 2;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_ERR     = 1;
  // reset values
  localparam logic [23:0] ADDR_RST   = 24'h000000;
  localparam logic [1:0]  IRQ_EN_RST = 2'h0;
  localparam logic [3:0]  PIN_RST    = 4'h5;
endpackage

// *** core/sfes_link_if.sv ***
// Purpose: serial link between host controller and flash erase device
// Assumes: spi mode 0, host drives the link clock
// Notes:   ready and fail are the device status levels
`timescale 1ns/1ps
`default_nettype none
interface sfes_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic ready;
  logic fail;
  modport host (output sck, output cs_n, output mosi,
                input ready, input fail);
  modport dev  (input sck, input cs_n, input mosi,
                output ready, output fail);
endinterface
`default_nettype wire

// *** core/sfes_device.sv ***
// Purpose: erase command decoder and self-timed erase sequencer
// Assumes: link pins come from another clock domain
// Notes:   array itself lives outside, driven by erase requests
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module sfes_device #(
  parameter int unsigned BLOCK_CYC  = sfes_pkg::BLOCK_ERASE_CYC,
  parameter int unsigned SECTOR_CYC = sfes_pkg::SECTOR_ERASE_CYC,
  parameter int unsigned CHIP_CYC   = sfes_pkg::CHIP_ERASE_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        page_size_512,
  input  wire logic [63:0] sector_protect,
  input  wire logic [63:0] sector_lock,
  input  wire logic        wp_n,
  input  wire logic        array_verify_fail,
  sfes_link_if.dev         link,
  output logic             erase_req,
  output logic [12:0]      erase_page_first,
  output logic [7:0]       erase_page_count,
  output logic [7:0]       erase_fill,
  output logic             erase_error,
  output logic             device_ready,
  output logic             hw_protect_active
);
  typedef enum logic [1:0] {SFES_IDLE, SFES_WALK, SFES_RUN} sfes_state_e;

  logic [3:0]  pin_s1_q;
  logic [3:0]  pin_s2_q;
  logic        sck_prev_q;
  logic        cs_prev_q;
  logic [7:0]  shift_q;
  logic [2:0]  bit_q;
  logic [2:0]  idx_q;
  logic [7:0]  opcode_q;
  logic [23:0] addr_q;
  logic        chip_ok_q;
  sfes_state_e state_q;
  logic [31:0] timer_q;
  logic [31:0] limit_q;
  logic        chip_run_q;
  logic [5:0]  walk_q;
  logic        req_q;
  logic [12:0] first_q;
  logic [7:0]  count_q;
  logic        ready_q;
  logic        err_q;
  logic        prot_q;
  logic [7:0]  fill_q;

  logic        sck_s;
  logic        cs_s;
  logic        mosi_s;
  logic        wp_s;
  logic        sck_rise;
  logic        cs_rise;
  logic        cs_fall;
  logic [7:0]  byte_in;
  logic [9:0]  blk;
  logic [20:0] span;
  logic        framed;
  logic        go_block;
  logic        go_sector;
  logic        go_chip;

  // expected byte of the chip erase sequence at a position
  function automatic logic [7:0] chip_byte(input logic [2:0] i);
    logic [7:0] r;
    r = sfes_pkg::OP_CHIP_1;
    unique case (i)
      3'h1: r = sfes_pkg::OP_CHIP_2;
      3'h2: r = sfes_pkg::OP_CHIP_3;
      3'h3: r = sfes_pkg::OP_CHIP_4;
      default: r = sfes_pkg::OP_CHIP_1;
    endcase
    return r;
  endfunction

  // block number from the address bytes in either page layout
  function automatic logic [9:0] block_of(input logic [23:0] a,
                                          input logic m512);
    return m512 ? a[21:12] : a[22:13];
  endfunction

  // sector first page and page count from a block number
  function automatic logic [20:0] sector_span(input logic [9:0] b);
    logic [20:0] r;
    r = {b[9:4], 7'h00, sfes_pkg::PAGES_PER_SECTOR};
    if (b[9:4] == 6'h00)
    begin
      if (b[3:0] == 4'h0)
        r = {13'h0000, sfes_pkg::PAGES_PER_BLOCK};
      else
        r = {13'h0008, sfes_pkg::SECTOR0B_PAGES};
    end
    return r;
  endfunction

  assign sck_s    = pin_s2_q[3];
  assign cs_s     = pin_s2_q[2];
  assign mosi_s   = pin_s2_q[1];
  assign wp_s     = pin_s2_q[0];
  assign sck_rise = sck_s & ~sck_prev_q;
  assign cs_rise  = cs_s & ~cs_prev_q;
  assign cs_fall  = ~cs_s & cs_prev_q;
  assign byte_in  = {shift_q[6:0], mosi_s};
  assign blk      = block_of(addr_q, page_size_512);
  assign span     = sector_span(blk);
  assign framed   = (bit_q == 3'h0);
  assign go_block  = cs_rise && framed && ready_q && idx_q == 3'h4 &&
                     opcode_q == sfes_pkg::OP_BLOCK_ERASE;
  assign go_sector = cs_rise && framed && ready_q && idx_q == 3'h4 &&
                     opcode_q == sfes_pkg::OP_SECTOR_ERASE;
  assign go_chip   = cs_rise && framed && ready_q && idx_q >= 3'h4 &&
                     chip_ok_q;

  // two-flop synchroniser for link pins and write protect
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_s1_q   <= sfes_pkg::PIN_RST;
      pin_s2_q   <= sfes_pkg::PIN_RST;
      sck_prev_q <= 1'b0;
      cs_prev_q  <= 1'b1;
    end
    else
    begin
      pin_s1_q   <= {link.sck, link.cs_n, link.mosi, wp_n};
      pin_s2_q   <= pin_s1_q;
      sck_prev_q <= sck_s;
      cs_prev_q  <= cs_s;
    end
  end

  // serial receive of opcode and address bytes
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      shift_q   <= 8'h00;
      bit_q     <= 3'h0;
      idx_q     <= 3'h0;
      opcode_q  <= 8'h00;
      addr_q    <= 24'h000000;
      chip_ok_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      bit_q     <= 3'h0;
      idx_q     <= 3'h0;
      chip_ok_q <= 1'b0;
    end
    else if (sck_rise && !cs_s)
    begin
      shift_q <= byte_in;
      bit_q   <= bit_q + 3'h1;
      if (bit_q == 3'h7)
      begin
        if (idx_q == 3'h0)
        begin
          opcode_q  <= byte_in;
          chip_ok_q <= (byte_in == sfes_pkg::OP_CHIP_1);
        end
        else if (idx_q < 3'h4)
        begin
          addr_q    <= {addr_q[15:0], byte_in};
          chip_ok_q <= chip_ok_q && (byte_in == chip_byte(idx_q));
        end
        // later bytes are not used; the byte count stops at 5
        if (idx_q != 3'h5)
          idx_q <= idx_q + 3'h1;
      end
    end
  end

  // erase sequencing and busy timing
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q    <= SFES_IDLE;
      timer_q    <= 32'h00000000;
      limit_q    <= 32'h00000000;
      chip_run_q <= 1'b0;
      walk_q     <= 6'h00;
      req_q      <= 1'b0;
      first_q    <= 13'h0000;
      count_q    <= 8'h00;
      ready_q    <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        SFES_IDLE:
        begin
          req_q   <= 1'b0;
          timer_q <= 32'h00000000;
          if (go_block)
          begin
            ready_q <= 1'b0;
            limit_q <= BLOCK_CYC;
            req_q   <= 1'b1;
            first_q <= {blk, 3'h0};
            count_q <= sfes_pkg::PAGES_PER_BLOCK;
            state_q <= SFES_RUN;
          end
          else if (go_sector)
          begin
            ready_q <= 1'b0;
            limit_q <= SECTOR_CYC;
            req_q   <= 1'b1;
            first_q <= span[20:8];
            count_q <= span[7:0];
            state_q <= SFES_RUN;
          end
          else if (go_chip)
          begin
            ready_q    <= 1'b0;
            limit_q    <= CHIP_CYC;
            chip_run_q <= 1'b1;
            walk_q     <= 6'h00;
            state_q    <= SFES_WALK;
          end
        end
        SFES_WALK:
        begin
          timer_q <= timer_q + 32'h00000001;
          req_q   <= ~(sector_protect[walk_q] | sector_lock[walk_q]);
          first_q <= {walk_q, 7'h00};
          count_q <= sfes_pkg::PAGES_PER_SECTOR;
          walk_q  <= walk_q + 6'h01;
          if (walk_q == 6'(sfes_pkg::NUM_SECTORS - 1))
            state_q <= SFES_RUN;
        end
        SFES_RUN:
        begin
          req_q   <= 1'b0;
          timer_q <= timer_q + 32'h00000001;
          if (timer_q + 32'h00000001 >= limit_q)
          begin
            ready_q    <= 1'b1;
            chip_run_q <= 1'b0;
            state_q    <= SFES_IDLE;
          end
        end
      endcase
    end
  end

  // verify failure during an erase; a new erase clears the flag
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      err_q <= 1'b0;
    else if (!ready_q && array_verify_fail)
      err_q <= 1'b1;
    else if (go_block || go_sector || go_chip)
      err_q <= 1'b0;
  end

  // hardware protection follows the pin except during chip erase
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      prot_q <= 1'b0;
    else if (!chip_run_q)
      prot_q <= ~wp_s;
  end

  // erased cells hold all ones
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      fill_q <= sfes_pkg::ERASED_FILL;
    else
      fill_q <= sfes_pkg::ERASED_FILL;
  end

  assign erase_req         = req_q;
  assign erase_page_first  = first_q;
  assign erase_page_count  = count_q;
  assign erase_fill        = fill_q;
  assign erase_error       = err_q;
  assign device_ready      = ready_q;
  assign hw_protect_active = prot_q;
  assign link.ready        = ready_q;
  assign link.fail         = err_q;
endmodule
`default_nettype wire

// *** core/sfes_host.sv ***
// Purpose: host controller issuing erase commands over the serial link
// Assumes: avalon-mm slave with waitrequest, link clock made here
// Notes:   every command frame is four bytes, msb first, spi mode 0
`timescale 1ns/1ps
`default_nettype none
module sfes_host (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  sfes_link_if.host        link
);
  typedef enum logic [2:0] {
    SFEH_IDLE, SFEH_SHIFT, SFEH_TRAIL, SFEH_WAIT_BUSY, SFEH_WAIT_READY
  } sfeh_state_e;

  logic [1:0]  st_s1_q;
  logic [1:0]  st_s2_q;
  logic        fail_prev_q;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [23:0] addr_q;
  logic [1:0]  irq_en_q;
  logic [1:0]  irq_st_q;
  logic        irq_q;
  sfeh_state_e state_q;
  logic [31:0] frame_q;
  logic [2:0]  div_q;
  logic [4:0]  bits_q;
  logic        sck_q;
  logic        cs_n_q;
  logic        mosi_q;
  logic        done_ev;

  logic        rdy_s;
  logic        fail_s;
  logic        wr_fire;
  logic        tick;
  logic        launch;
  logic [31:0] frame_d;
  logic [1:0]  irq_set;

  assign rdy_s   = st_s2_q[1];
  assign fail_s  = st_s2_q[0];
  assign wr_fire = avs_write && !wait_q;
  assign tick    = (div_q == 3'(sfes_pkg::SCK_HALF_CYC - 1));
  assign launch  = wr_fire && avs_address == sfes_pkg::REG_CMD &&
                   state_q == SFEH_IDLE && rdy_s &&
                   avs_writedata[1:0] != 2'h3;
  assign irq_set = {fail_s & ~fail_prev_q, done_ev};

  always_comb
  begin
    frame_d = {sfes_pkg::OP_BLOCK_ERASE, addr_q};
    unique case (avs_writedata[1:0])
      sfes_pkg::KIND_SECTOR:
        frame_d = {sfes_pkg::OP_SECTOR_ERASE, addr_q};
      sfes_pkg::KIND_CHIP:
        frame_d = {sfes_pkg::OP_CHIP_1, sfes_pkg::OP_CHIP_2,
                   sfes_pkg::OP_CHIP_3, sfes_pkg::OP_CHIP_4};
      default:
        frame_d = {sfes_pkg::OP_BLOCK_ERASE, addr_q};
    endcase
  end

  // two-flop synchroniser for device status levels
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_s1_q     <= 2'h2;
      st_s2_q     <= 2'h2;
      fail_prev_q <= 1'b0;
    end
    else
    begin
      st_s1_q     <= {link.ready, link.fail};
      st_s2_q     <= st_s1_q;
      fail_prev_q <= fail_s;
    end
  end

  // bus answer: waitrequest drops for one cycle per request
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else if ((avs_read || avs_write) && wait_q)
    begin
      wait_q  <= 1'b0;
      rdata_q <= 32'h00000000;
      if (avs_read)
      begin
        unique case (avs_address)
          sfes_pkg::REG_ADDR:     rdata_q <= {8'h00, addr_q};
          sfes_pkg::REG_STATUS:   rdata_q <= {29'h0, fail_s, ~rdy_s,
                                              state_q != SFEH_IDLE};
          sfes_pkg::REG_IRQ_STAT: rdata_q <= {30'h0, irq_st_q};
          sfes_pkg::REG_IRQ_EN:   rdata_q <= {30'h0, irq_en_q};
          default:                rdata_q <= 32'h00000000;
        endcase
      end
    end
    else
      wait_q <= 1'b1;
  end

  // software registers
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_q   <= sfes_pkg::ADDR_RST;
      irq_en_q <= sfes_pkg::IRQ_EN_RST;
    end
    else if (wr_fire && avs_address == sfes_pkg::REG_ADDR)
      addr_q <= avs_writedata[23:0];
    else if (wr_fire && avs_address == sfes_pkg::REG_IRQ_EN)
      irq_en_q <= avs_writedata[1:0];
  end

  // sticky events, a new event wins over a clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_st_q <= 2'h0;
      irq_q    <= 1'b0;
    end
    else
    begin
      if (wr_fire && avs_address == sfes_pkg::REG_IRQ_CLR)
        irq_st_q <= (irq_st_q & ~avs_writedata[1:0]) | irq_set;
      else
        irq_st_q <= irq_st_q | irq_set;
      irq_q <= |(irq_st_q & irq_en_q);
    end
  end

  // frame engine and link clock divider
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= SFEH_IDLE;
      frame_q <= 32'h00000000;
      div_q   <= 3'h0;
      bits_q  <= 5'h00;
      sck_q   <= 1'b0;
      cs_n_q  <= 1'b1;
      mosi_q  <= 1'b0;
      done_ev <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      div_q   <= tick ? 3'h0 : div_q + 3'h1;
      unique case (state_q)
        SFEH_IDLE:
        begin
          div_q <= 3'h0;
          if (launch)
          begin
            frame_q <= frame_d;
            mosi_q  <= frame_d[31];
            cs_n_q  <= 1'b0;
            bits_q  <= 5'h00;
            state_q <= SFEH_SHIFT;
          end
        end
        SFEH_SHIFT:
          if (tick)
          begin
            if (!sck_q)
              sck_q <= 1'b1;
            else
            begin
              sck_q   <= 1'b0;
              frame_q <= {frame_q[30:0], 1'b0};
              mosi_q  <= frame_q[30];
              bits_q  <= bits_q + 5'h01;
              if (bits_q == 5'h1f)
                state_q <= SFEH_TRAIL;
            end
          end
        SFEH_TRAIL:
          if (tick)
          begin
            cs_n_q  <= 1'b1;
            state_q <= SFEH_WAIT_BUSY;
          end
        SFEH_WAIT_BUSY:
          if (!rdy_s)
            state_q <= SFEH_WAIT_READY;
        SFEH_WAIT_READY:
          if (rdy_s)
          begin
            done_ev <= 1'b1;
            state_q <= SFEH_IDLE;
          end
        default:
          state_q <= SFEH_IDLE;
      endcase
    end
  end

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq             = irq_q;
  assign link.sck        = sck_q;
  assign link.cs_n       = cs_n_q;
  assign link.mosi       = mosi_q;
endmodule
`default_nettype wire

// *** verification/sfes_checker.sv ***
// Purpose: link checks between host controller and erase device
// Assumes: host sends only whole four-byte frames
// Notes:   busy limits come in as parameters
`timescale 1ns/1ps
`default_nettype none
module sfes_checker #(
  parameter int unsigned BLOCK_CYC  = 100,
  parameter int unsigned SECTOR_CYC = 150,
  parameter int unsigned CHIP_CYC   = 200
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic ready,
  input wire logic fail
);
  logic [31:0] busy_q;
  logic [7:0]  bits_q;
  logic        sck_q;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      busy_q <= '0;
    else
      busy_q <= ready ? 32'h0 : busy_q + 32'h1;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      sck_q <= 1'b0;
    else
      sck_q <= sck;
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      bits_q <= '0;
    else if (cs_n)
      bits_q <= '0;
    else if (sck && !sck_q)
      bits_q <= bits_q + 8'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_frame_end;
    $rose(cs_n);
  endsequence
  sequence s_busy_begin;
    $fell(ready);
  endsequence
  property p_busy_start;
    s_frame_end |-> ##[1:6] s_busy_begin;
  endproperty
  property p_busy_len;
    $rose(ready) |-> busy_q inside {BLOCK_CYC, SECTOR_CYC, CHIP_CYC};
  endproperty
  property p_busy_cs;
    !ready |-> cs_n;
  endproperty
  property p_fail_set;
    $rose(fail) |-> !$past(ready);
  endproperty
  property p_fail_hold;
    ready && $past(ready) |-> $stable(fail);
  endproperty
  property p_sck_idle;
    cs_n |-> !sck;
  endproperty
  property p_sck_half;
    $rose(sck) |-> sck[*4] ##1 !sck;
  endproperty
  property p_mosi_hold;
    sck && $past(sck) |-> $stable(mosi);
  endproperty
  property p_bits;
    s_frame_end |-> bits_q == 8'h20;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy did not follow frame end");
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");
  a_busy_cs: assert property (p_busy_cs)
    else $error("frame during busy");
  a_fail_set: assert property (p_fail_set)
    else $error("error flag rose while ready");
  a_fail_hold: assert property (p_fail_hold)
    else $error("error flag moved while ready");
  a_sck_idle: assert property (p_sck_idle)
    else $error("link clock not idle low");
  a_sck_half: assert property (p_sck_half)
    else $error("link clock half period wrong");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("data moved while link clock high");
  a_bits: assert property (p_bits)
    else $error("frame not 32 bits");
endmodule
`default_nettype wire

// *** verification/sfes_test.sv ***
// Purpose: self-checking bench for host and erase device joined
// Assumes: small erase limits 100/150/200 cycles
// Notes:   erase requests captured in a queue per command
`timescale 1ns/1ps
`default_nettype none
module sfes_test;
  logic        clock;
  logic        nrst;
  logic        page_size_512;
  logic [63:0] sector_protect;
  logic [63:0] sector_lock;
  logic        wp_n;
  logic        array_verify_fail;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        erase_req;
  logic [12:0] erase_page_first;
  logic [7:0]  erase_page_count;
  logic [7:0]  erase_fill;
  logic        erase_error;
  logic        device_ready;
  logic        hw_protect_active;
  int          error_cnt = 0;
  int          n_tests = 0;
  logic [20:0] reqs[$];
  logic [31:0] rd;
  logic [9:0]  blk[3] = '{10'd0, 10'd5, 10'd1023};
  logic [12:0] sec_pg[5] = '{13'h7, 13'h8, 13'h78, 13'hff, 13'h1fd5};
  logic [20:0] sec_exp[5] = '{{13'h0, 8'h08}, {13'h8, 8'h78},
    {13'h8, 8'h78}, {13'h80, 8'h80}, {13'h1f80, 8'h80}};
  // small erase limits, the checker defaults carry the same values
  localparam int unsigned T_BLK  = 100;
  localparam int unsigned T_SEC  = 150;
  localparam int unsigned T_CHIP = 200;
  sfes_link_if link ();
  sfes_device #(.BLOCK_CYC(T_BLK), .SECTOR_CYC(T_SEC), .CHIP_CYC(T_CHIP))
  sfes_device_inst (.clock(clock), .nrst(nrst),
    .page_size_512(page_size_512), .sector_protect(sector_protect),
    .sector_lock(sector_lock), .wp_n(wp_n),
    .array_verify_fail(array_verify_fail), .link(link),
    .erase_req(erase_req), .erase_page_first(erase_page_first),
    .erase_page_count(erase_page_count), .erase_fill(erase_fill),
    .erase_error(erase_error), .device_ready(device_ready),
    .hw_protect_active(hw_protect_active));
  sfes_host sfes_host_inst (.clock(clock), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq), .link(link));
  sfes_checker sfes_checker_inst (.clock(clock), .nrst(nrst), .sck(link.sck),
    .cs_n(link.cs_n), .mosi(link.mosi), .ready(link.ready),
    .fail(link.fail));
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock)
    if (erase_req === 1'b1)
      reqs.push_back({erase_page_first, erase_page_count});
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (i >= 50)
    begin
      error_cnt++;
      final_report();
    end
  endtask
  task automatic wait_rdy(input logic v);
    int i;
    i = 0;
    while (device_ready !== v && i < 3000)
    begin
      @(posedge clock);
      i++;
    end
    if (i >= 3000)
    begin
      error_cnt++;
      final_report();
    end
  endtask
  function automatic logic [31:0] mkaddr(input logic m,
                                         input logic [12:0] p);
    return m ? {8'h0, 2'b10, p, 9'h1ff} : {8'h0, 1'b1, p, 10'h3ff};
  endfunction
  task automatic run(input logic [1:0] k, input logic [31:0] a,
                     input logic mid);
    int j;
    reqs.delete();
    bus(1'b1, sfes_pkg::REG_ADDR, a);
    bus(1'b1, sfes_pkg::REG_CMD, {30'h0, k});
    wait_rdy(1'b0);
    if (mid)
    begin
      repeat (10) @(posedge clock);
      wp_n <= 1'b0;
      array_verify_fail <= 1'b1;
      @(posedge clock);
      array_verify_fail <= 1'b0;
      repeat (5) @(posedge clock);
      chk("wp_deferred", hw_protect_active, 1'b0);
    end
    wait_rdy(1'b1);
    j = 0;
    do
    begin
      bus(1'b0, sfes_pkg::REG_STATUS, 32'h0);
      j++;
    end
    while (rd[sfes_pkg::ST_SENDING] !== 1'b0 && j < 20);
    chk("sending", rd[sfes_pkg::ST_SENDING], 1'b0);
  endtask
  task automatic t_reset();
    chk("ready", device_ready, 1'b1);
    chk("fill", erase_fill, 8'hff);
    bus(1'b0, sfes_pkg::REG_IRQ_EN, 32'h0);
    chk("irq_en", rd, 32'h0);
    bus(1'b1, 3'h7, 32'hffff_ffff);
    bus(1'b0, 3'h7, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, sfes_pkg::REG_ADDR, 32'hffff_ffff);
    bus(1'b0, sfes_pkg::REG_ADDR, 32'h0);
    chk("addr_rb", rd, 32'h00ff_ffff);
  endtask
  task automatic t_block();
    for (int m = 0; m < 2; m++)
      for (int b = 0; b < 3; b++)
      begin
        page_size_512 <= m[0];
        run(sfes_pkg::KIND_BLOCK, mkaddr(m[0], {blk[b], 3'b111}), 1'b0);
        chk("blk_n", reqs.size(), 1);
        chk("blk_req", reqs[0], {blk[b], 3'b000, 8'h08});
      end
  endtask
  task automatic t_sector();
    for (int m = 0; m < 2; m++)
      for (int s = 0; s < 5; s++)
      begin
        page_size_512 <= m[0];
        run(sfes_pkg::KIND_SECTOR, mkaddr(m[0], sec_pg[s]), 1'b0);
        chk("sec_n", reqs.size(), 1);
        chk("sec_req", reqs[0], sec_exp[s]);
      end
  endtask
  task automatic t_chip();
    int idx;
    page_size_512 <= 1'b0;
    sector_protect <= 64'h4;
    sector_lock <= 64'h20;
    bus(1'b1, sfes_pkg::REG_IRQ_EN, 32'h3);
    run(sfes_pkg::KIND_CHIP, 32'h0, 1'b1);
    chk("status_err", rd, 32'h4);
    chk("chip_n", reqs.size(), 62);
    idx = 0;
    for (int i = 0; i < 64; i++)
      if (i != 2 && i != 5)
      begin
        chk("chip_req", reqs[idx], {i[5:0], 7'h0, 8'h80});
        idx++;
      end
    chk("fail", erase_error, 1'b1);
    chk("wp_on", hw_protect_active, 1'b1);
    bus(1'b0, sfes_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq_stat", rd, 32'h3);
    chk("irq", irq, 1'b1);
    bus(1'b1, sfes_pkg::REG_IRQ_CLR, 32'h3);
    bus(1'b1, sfes_pkg::REG_IRQ_EN, 32'h0);
    bus(1'b0, sfes_pkg::REG_IRQ_STAT, 32'h0);
    chk("irq_clr", rd, 32'h0);
    run(sfes_pkg::KIND_BLOCK, 32'h0, 1'b0);
    chk("fail_clr", erase_error, 1'b0);
    chk("irq_mask", irq, 1'b0);
  endtask
  initial
  begin
    nrst = 1'b0;
    page_size_512 = 1'b0;
    sector_protect = 64'h0;
    sector_lock = 64'h0;
    wp_n = 1'b1;
    array_verify_fail = 1'b0;
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    repeat (2) @(posedge clock);
    t_reset();
    t_block();
    t_sector();
    t_chip();
    final_report();
  end
endmodule
`default_nettype wire
